// file: rtl/smcg_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl
  import smcg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       sleep_instr,
  input  wire logic       global_irq_en,
  input  wire logic       irq_pending,
  input  wire logic       wake_reset,
  input  wire logic       wake_watchdog,
  input  wire logic       wake_two_wire,
  input  wire logic       wake_ext_level,
  input  wire logic       wake_pin_change,
  input  wire logic       wake_converter_done,
  input  wire logic       wake_self_program,
  input  wire logic       wake_timer_two,
  input  wire logic       timer_two_irq_mask,
  input  wire logic       timer_two_async_select,
  input  wire logic       timer_two_enabled,
  input  wire logic       converter_enabled,
  input  wire logic       comparator_enabled,
  input  wire logic       comparator_uses_ref,
  input  wire logic       brownout_enabled,
  input  wire logic       watchdog_enabled,
  output logic            clk_en_cpu,
  output logic            clk_en_flash,
  output logic            clk_en_io,
  output logic            clk_en_adc,
  output logic            clk_en_async,
  output logic            osc_main_en,
  output logic            osc_timer_en,
  output logic      [7:0] periph_clk_en,
  output logic      [7:0] periph_access_en,
  output logic            converter_start,
  output logic            converter_extended,
  output logic            comparator_mux_ok,
  output logic            comparator_active,
  output logic            vref_en,
  output logic            watchdog_run,
  output logic            input_buf_en,
  output logic            wake_irq_take,
  output logic            core_halted
);

  smcg_state_t state_ff;
  smcg_state_t nxt_state;
  logic [7:0]  sc_ff;
  logic [7:0]  nxt_sc;
  logic [7:0]  pg_ff;
  logic [7:0]  nxt_pg;
  logic [7:0]  wc_ff;
  logic [7:0]  nxt_wc;
  logic [2:0]  mode_ff;
  logic [2:0]  nxt_mode;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        conv_off_ff;
  logic        nxt_conv_off;
  logic        ext_ff;
  logic        nxt_ext;
  logic        start_ff;
  logic        nxt_start;
  logic        irq_wake_ff;
  logic        nxt_irq_wake;
  logic        tmr_load;
  logic [19:0] tmr_count;
  logic        tmr_busy;
  logic        tmr_done;
  logic        wake_hit;
  logic        sleeping;
  logic [2:0]  cur_mode;

  function automatic logic [19:0] startup_cycles(input logic [1:0] sel);
    int us;
    case (sel)
      2'h0:    us = SMCG_STARTUP_US_0;
      2'h1:    us = SMCG_STARTUP_US_1;
      2'h2:    us = SMCG_STARTUP_US_2;
      default: us = SMCG_STARTUP_US_3;
    endcase
    startup_cycles = 20'((us * 1000 + SMCG_CLK_PERIOD_NS - 1) / SMCG_CLK_PERIOD_NS);
  endfunction

  // legal sleep code for the current crystal setting
  function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
    mode_valid = (m == SMCG_MODE_IDLE) || (m == SMCG_MODE_NOISE) ||
                 (m == SMCG_MODE_PDOWN) || (m == SMCG_MODE_PSAVE) ||
                 ((m == SMCG_MODE_STANDBY) && xtal);
  endfunction

  function automatic logic deep_mode(input logic [2:0] m);
    deep_mode = (m == SMCG_MODE_PDOWN) || (m == SMCG_MODE_PSAVE) ||
                (m == SMCG_MODE_STANDBY);
  endfunction

  assign sleeping = (state_ff == SMCG_ST_SLEEP) || (state_ff == SMCG_ST_STARTUP);
  assign cur_mode = mode_ff;

  // wake source qualification per mode
  always_comb begin
    wake_hit = wake_reset || wake_watchdog || wake_two_wire ||
               wake_ext_level || wake_pin_change;
    unique case (cur_mode)
      SMCG_MODE_IDLE:  wake_hit = wake_hit || irq_pending || wake_converter_done;
      SMCG_MODE_NOISE: wake_hit = wake_hit || wake_converter_done ||
                                  wake_self_program || wake_timer_two;
      SMCG_MODE_PSAVE: wake_hit = wake_hit || (wake_timer_two &&
                                  timer_two_irq_mask && global_irq_en);
      default:         wake_hit = wake_hit;
    endcase
  end

  // sleep sequencer
  always_comb begin
    nxt_state    = state_ff;
    nxt_mode     = mode_ff;
    nxt_irq_wake = irq_wake_ff;
    nxt_start    = 1'b0;
    tmr_load     = 1'b0;
    tmr_count    = 20'h0_0000;
    unique case (state_ff)
      SMCG_ST_ACTIVE: begin
        nxt_irq_wake = 1'b0;
        if (sleep_instr && sc_ff[SMCG_SC_ARM_BIT] &&
            mode_valid(sc_ff[SMCG_SC_MODE_LSB +: 3], wc_ff[SMCG_WC_XTAL_SEL])) begin
          nxt_state = SMCG_ST_SLEEP;
          nxt_mode  = sc_ff[SMCG_SC_MODE_LSB +: 3];
          nxt_start = (sc_ff[SMCG_SC_MODE_LSB +: 3] == SMCG_MODE_NOISE) &&
                      converter_enabled;
        end
      end
      SMCG_ST_SLEEP: begin
        if (wake_hit) begin
          nxt_irq_wake = !wake_reset;
          nxt_state    = SMCG_ST_STARTUP;
          tmr_load     = 1'b1;
          if (mode_ff == SMCG_MODE_STANDBY) begin
            tmr_count = 20'(SMCG_STANDBY_WAKE_CYC);
          end else if (deep_mode(mode_ff)) begin
            tmr_count = startup_cycles(wc_ff[SMCG_WC_STARTUP_LSB +: 2]);
          end else begin
            tmr_count = 20'h0_0001;
          end
        end
      end
      SMCG_ST_STARTUP: begin
        if (tmr_done) begin
          if (irq_wake_ff) begin
            nxt_state = SMCG_ST_HALT;
            tmr_load  = 1'b1;
            tmr_count = 20'(SMCG_HALT_EXTRA_CYC);
          end else begin
            nxt_state = SMCG_ST_ACTIVE;
          end
        end
      end
      SMCG_ST_HALT: begin
        if (tmr_done) begin
          nxt_state = SMCG_ST_ACTIVE;
        end
      end
      default: nxt_state = SMCG_ST_ACTIVE;
    endcase
  end

  // register file
  always_comb begin
    nxt_sc    = sc_ff;
    nxt_pg    = pg_ff;
    nxt_wc    = wc_ff;
    nxt_rdata = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        SMCG_ADDR_SLEEP_CTRL:  nxt_sc = reg_wdata & 8'h0F;
        SMCG_ADDR_PERIPH_GATE: nxt_pg = reg_wdata & SMCG_PG_WRITE_MASK;
        SMCG_ADDR_WAKE_CFG:    nxt_wc = reg_wdata & 8'h07;
        default:               nxt_sc = sc_ff;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        SMCG_ADDR_SLEEP_CTRL:  nxt_rdata = sc_ff;
        SMCG_ADDR_PERIPH_GATE: nxt_rdata = pg_ff;
        SMCG_ADDR_STATUS:      nxt_rdata = {3'h0, ext_ff, mode_ff, sleeping};
        SMCG_ADDR_WAKE_CFG:    nxt_rdata = wc_ff;
        default:               nxt_rdata = 8'h00;
      endcase
    end
  end

  // converter off/on tracking for the extended conversion flag
  always_comb begin
    nxt_conv_off = !converter_enabled;
    nxt_ext      = ext_ff;
    if (conv_off_ff && converter_enabled) begin
      nxt_ext = 1'b1;
    end else if (converter_start) begin
      nxt_ext = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff    <= SMCG_ST_ACTIVE;
      mode_ff     <= SMCG_MODE_IDLE;
      sc_ff       <= SMCG_SC_RESET;
      pg_ff       <= SMCG_PG_RESET;
      wc_ff       <= SMCG_WC_RESET;
      rdata_ff    <= 8'h00;
      conv_off_ff <= 1'b0;
      ext_ff      <= 1'b0;
      start_ff    <= 1'b0;
      irq_wake_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      mode_ff     <= nxt_mode;
      sc_ff       <= nxt_sc;
      pg_ff       <= nxt_pg;
      wc_ff       <= nxt_wc;
      rdata_ff    <= nxt_rdata;
      conv_off_ff <= nxt_conv_off;
      ext_ff      <= nxt_ext;
      start_ff    <= nxt_start;
      irq_wake_ff <= nxt_irq_wake;
    end
  end

  smcg_wake_timer u_wake_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (tmr_load),
    .count   (tmr_count),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // clock domain enables
  logic in_sleep;
  logic deep;
  logic t2_sync_gated;
  assign in_sleep = (state_ff == SMCG_ST_SLEEP);
  assign deep     = in_sleep && deep_mode(mode_ff);

  assign clk_en_cpu   = (state_ff == SMCG_ST_ACTIVE);
  assign clk_en_flash = (state_ff == SMCG_ST_ACTIVE);
  assign clk_en_io    = !(in_sleep && mode_ff != SMCG_MODE_IDLE);
  assign clk_en_adc   = !deep;
  assign clk_en_async = !(deep && mode_ff != SMCG_MODE_PSAVE) &&
                        (!deep || timer_two_async_select);
  assign osc_main_en  = !(deep && mode_ff == SMCG_MODE_PDOWN) &&
                        !(deep && mode_ff == SMCG_MODE_PSAVE &&
                          (timer_two_async_select || !timer_two_enabled));
  assign osc_timer_en = timer_two_async_select &&
                        !(deep && mode_ff != SMCG_MODE_PSAVE);

  // per-peripheral gating, only meaningful while io clock runs
  assign t2_sync_gated = pg_ff[SMCG_PG_TIMER_TWO] && !timer_two_async_select;
  always_comb begin
    periph_access_en = ~pg_ff;
    periph_access_en[SMCG_PG_RESERVED] = 1'b0;
    periph_access_en[SMCG_PG_TIMER_TWO] = !t2_sync_gated;
    periph_clk_en = periph_access_en & {8{clk_en_io}};
    // in power-save the running sync clock feeds timer two only
    if (deep && mode_ff == SMCG_MODE_PSAVE) begin
      periph_clk_en[SMCG_PG_TIMER_TWO] = timer_two_enabled && !timer_two_async_select;
    end
  end

  assign converter_start    = start_ff;
  assign converter_extended = ext_ff;
  assign comparator_mux_ok  = !pg_ff[SMCG_PG_CONVERTER];
  assign comparator_active  = comparator_enabled && (!deep || comparator_uses_ref);
  assign vref_en            = brownout_enabled || converter_enabled ||
                              (comparator_active && comparator_uses_ref);
  assign watchdog_run       = watchdog_enabled;
  assign input_buf_en       = !deep;
  assign wake_irq_take      = (state_ff == SMCG_ST_HALT) && tmr_done;
  assign core_halted        = (state_ff != SMCG_ST_ACTIVE);
  assign reg_rdata          = rdata_ff;

  sequence s_wake_irq;
    (state_ff == SMCG_ST_STARTUP) && tmr_done && irq_wake_ff;
  endsequence

  a_halt_four_cycles: assert property (@(posedge clk_sys) disable iff (rst)
    s_wake_irq |=> (state_ff == SMCG_ST_HALT) [*4] ##1 (state_ff == SMCG_ST_ACTIVE))
    else $error("halt after wake not four cycles");
  a_standby_six: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sleep && mode_ff == SMCG_MODE_STANDBY && wake_hit)
      |=> (state_ff == SMCG_ST_STARTUP) [*6] ##1 (state_ff != SMCG_ST_STARTUP))
    else $error("standby wake not six cycles");
  a_reserved_no_sleep: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == SMCG_ST_ACTIVE &&
     !mode_valid(sc_ff[SMCG_SC_MODE_LSB +: 3], wc_ff[SMCG_WC_XTAL_SEL]))
      |=> state_ff == SMCG_ST_ACTIVE)
    else $error("reserved code entered sleep");
  a_timer_runs_wake: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == SMCG_ST_STARTUP || state_ff == SMCG_ST_HALT) |-> tmr_busy)
    else $error("wake timer idle during wake-up");
  a_idle_clocks: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sleep && mode_ff == SMCG_MODE_IDLE) |-> (clk_en_io && clk_en_adc && !clk_en_cpu))
    else $error("idle clocks wrong");
  a_noise_start: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == SMCG_ST_ACTIVE && nxt_state == SMCG_ST_SLEEP &&
     nxt_mode == SMCG_MODE_NOISE && converter_enabled) |=> converter_start)
    else $error("no conversion on noise entry");
  a_pdown_osc_off: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sleep && mode_ff == SMCG_MODE_PDOWN) |-> (!osc_main_en && !clk_en_io && !clk_en_adc))
    else $error("power-down clocks running");
  a_gate_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == SMCG_ADDR_PERIPH_GATE |-> !reg_rdata[4])
    else $error("reserved gate bit reads one");
  a_psave_timer_wake: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sleep && mode_ff == SMCG_MODE_PSAVE && wake_timer_two &&
     !(timer_two_irq_mask && global_irq_en) &&
     !wake_reset && !wake_watchdog && !wake_two_wire && !wake_ext_level &&
     !wake_pin_change) |=> in_sleep)
    else $error("masked timer two woke power-save");

endmodule
`default_nettype wire

// file: rtl/smcg_pkg.sv
package smcg_pkg;

  // register map (word index on the plain register port)
  localparam logic [3:0] SMCG_ADDR_SLEEP_CTRL  = 4'h0;
  localparam logic [3:0] SMCG_ADDR_PERIPH_GATE = 4'h1;
  localparam logic [3:0] SMCG_ADDR_STATUS      = 4'h2;
  localparam logic [3:0] SMCG_ADDR_WAKE_CFG    = 4'h3;

  // sleep_control_reg fields
  localparam int SMCG_SC_ARM_BIT  = 0;
  localparam int SMCG_SC_MODE_LSB = 1;

  // peripheral_power_gate fields
  localparam int SMCG_PG_CONVERTER   = 0;
  localparam int SMCG_PG_SERIAL_PORT = 1;
  localparam int SMCG_PG_SERIAL_PER  = 2;
  localparam int SMCG_PG_TIMER_ONE   = 3;
  localparam int SMCG_PG_RESERVED    = 4;
  localparam int SMCG_PG_TIMER_ZERO  = 5;
  localparam int SMCG_PG_TIMER_TWO   = 6;
  localparam int SMCG_PG_TWO_WIRE    = 7;
  localparam logic [7:0] SMCG_PG_WRITE_MASK = 8'hEF;

  // wake configuration register fields
  localparam int SMCG_WC_XTAL_SEL   = 0;
  localparam int SMCG_WC_STARTUP_LSB = 1;

  localparam logic [7:0] SMCG_SC_RESET = 8'h00;
  localparam logic [7:0] SMCG_PG_RESET = 8'h00;
  localparam logic [7:0] SMCG_WC_RESET = 8'h00;

  // sleep mode select codes
  localparam logic [2:0] SMCG_MODE_IDLE    = 3'h0;
  localparam logic [2:0] SMCG_MODE_NOISE   = 3'h1;
  localparam logic [2:0] SMCG_MODE_PDOWN   = 3'h2;
  localparam logic [2:0] SMCG_MODE_PSAVE   = 3'h3;
  localparam logic [2:0] SMCG_MODE_STANDBY = 3'h6;

  // timing counts in clk_sys cycles, and the clk_sys period in ns
  localparam int SMCG_STANDBY_WAKE_CYC = 6;
  localparam int SMCG_HALT_EXTRA_CYC   = 4;
  localparam int SMCG_CLK_PERIOD_NS    = 100;
  // start-up delay options: 16 us, 1 ms, 4.1 ms, 65 ms, chosen by the startup field
  localparam int SMCG_STARTUP_US_0 = 16;
  localparam int SMCG_STARTUP_US_1 = 1000;
  localparam int SMCG_STARTUP_US_2 = 4100;
  localparam int SMCG_STARTUP_US_3 = 65000;

  typedef enum logic [2:0] {
    SMCG_ST_ACTIVE,
    SMCG_ST_SLEEP,
    SMCG_ST_STARTUP,
    SMCG_ST_HALT
  } smcg_state_t;

endpackage

// file: rtl/smcg_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter: loads a cycle count, pulses done when it reaches one
module smcg_wake_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [19:0] count,
  output logic             busy,
  output logic             done
);

  logic [19:0] cnt_ff;
  logic [19:0] nxt_cnt;
  logic        busy_ff;
  logic        nxt_busy;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (load) begin
      nxt_cnt  = count;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff <= 20'h0_0001) begin
        nxt_busy = 1'b0;
        nxt_cnt  = 20'h0_0000;
      end else begin
        nxt_cnt = cnt_ff - 20'h0_0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 20'h0_0000;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  // done must not look at load: the sequencer derives load from done
  assign done = busy_ff && (cnt_ff <= 20'h0_0001);

endmodule
`default_nettype wire

// file: verif/smcg_sleep_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define SMCG_CHK(act, exp) \
  begin \
    checked++; \
    if ((act) !== (exp)) begin \
      fail_count++; \
      $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp); \
    end \
  end
module smcg_sleep_ctrl_bench
  import smcg_pkg::*;
;
  logic       clk_sys;
  logic       rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       sleep_instr;
  logic       global_irq_en;
  logic [8:0] wk;
  logic       timer_two_irq_mask;
  logic       timer_two_async_select;
  logic       timer_two_enabled;
  logic       converter_enabled;
  logic       comparator_enabled;
  logic       comparator_uses_ref;
  logic       brownout_enabled;
  logic       watchdog_enabled;
  logic       clk_en_cpu;
  logic       clk_en_flash;
  logic       clk_en_io;
  logic       clk_en_adc;
  logic       clk_en_async;
  logic       osc_main_en;
  logic       osc_timer_en;
  logic [7:0] periph_clk_en;
  logic [7:0] periph_access_en;
  logic       converter_start;
  logic       converter_extended;
  logic       comparator_mux_ok;
  logic       comparator_active;
  logic       vref_en;
  logic       watchdog_run;
  logic       input_buf_en;
  logic       wake_irq_take;
  logic       core_halted;
  int         fail_count;
  int         checked;
  int         starts;
  int         takes;

  smcg_sleep_ctrl smcg_sleep_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .global_irq_en(global_irq_en), .irq_pending(wk[0]), .wake_reset(wk[1]),
    .wake_watchdog(wk[2]), .wake_two_wire(wk[3]), .wake_ext_level(wk[4]),
    .wake_pin_change(wk[5]), .wake_converter_done(wk[6]), .wake_self_program(wk[7]),
    .wake_timer_two(wk[8]), .timer_two_irq_mask(timer_two_irq_mask),
    .timer_two_async_select(timer_two_async_select), .timer_two_enabled(timer_two_enabled),
    .converter_enabled(converter_enabled), .comparator_enabled(comparator_enabled),
    .comparator_uses_ref(comparator_uses_ref), .brownout_enabled(brownout_enabled),
    .watchdog_enabled(watchdog_enabled), .clk_en_cpu(clk_en_cpu), .clk_en_flash(clk_en_flash),
    .clk_en_io(clk_en_io), .clk_en_adc(clk_en_adc), .clk_en_async(clk_en_async),
    .osc_main_en(osc_main_en), .osc_timer_en(osc_timer_en), .periph_clk_en(periph_clk_en),
    .periph_access_en(periph_access_en), .converter_start(converter_start),
    .converter_extended(converter_extended), .comparator_mux_ok(comparator_mux_ok),
    .comparator_active(comparator_active), .vref_en(vref_en), .watchdog_run(watchdog_run),
    .input_buf_en(input_buf_en), .wake_irq_take(wake_irq_take), .core_halted(core_halted)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (converter_start === 1'b1) begin
      starts++;
    end
    if (wake_irq_take === 1'b1) begin
      takes++;
    end
  end

  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `SMCG_CHK(reg_rdata, exp);
  endtask

  // arm, pick the mode, then issue the sleep instruction
  task automatic go_sleep(input logic [2:0] m);
    reg_write(SMCG_ADDR_SLEEP_CTRL, {4'h0, m, 1'b1});
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // raise one wake source, count edges until the core runs again
  task automatic wake_by(input int src, output int n);
    n = 0;
    @(posedge clk_sys);
    wk[src] <= 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (core_halted !== 1'b0 && n < 400);
    @(posedge clk_sys);
    wk <= '0;
  endtask

  logic [2:0] modes   [5] = '{SMCG_MODE_IDLE, SMCG_MODE_NOISE, SMCG_MODE_PDOWN,
                              SMCG_MODE_PSAVE, SMCG_MODE_STANDBY};
  // {cpu, flash, io, adc, main osc, input buffers, comparator, async clock, timer osc}
  logic [8:0] exp_dom [5] = '{9'h07F, 9'h03F, 9'h000, 9'h003, 9'h010};
  int         wsrc    [5] = '{0, 6, 4, 8, 5};
  int         startup_cyc;
  int         extra   [5];
  int         n_idle;
  int         n;
  int         s0;
  logic [2:0] rsv     [3] = '{3'h4, 3'h5, 3'h7};

  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_instr = 1'b0;
    global_irq_en = 1'b1;
    wk = '0;
    timer_two_irq_mask = 1'b0;
    timer_two_async_select = 1'b0;
    timer_two_enabled = 1'b1;
    converter_enabled = 1'b0;
    comparator_enabled = 1'b0;
    comparator_uses_ref = 1'b0;
    brownout_enabled = 1'b0;
    watchdog_enabled = 1'b1;
    fail_count = 0;
    checked = 0;
    starts = 0;
    takes = 0;
    startup_cyc = SMCG_STARTUP_US_0 * 1000 / SMCG_CLK_PERIOD_NS;
    extra = '{0, 0, startup_cyc - 1, startup_cyc - 1, SMCG_STANDBY_WAKE_CYC - 1};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chk_read(SMCG_ADDR_SLEEP_CTRL, 8'h00);
    chk_read(SMCG_ADDR_PERIPH_GATE, 8'h00);
    chk_read(SMCG_ADDR_WAKE_CFG, 8'h00);
    chk_read(4'hF, 8'h00);
    `SMCG_CHK(vref_en, 1'b0);
    @(posedge clk_sys);
    brownout_enabled <= 1'b1;
    @(posedge clk_sys);
    #1;
    `SMCG_CHK(vref_en, 1'b1);
    // gate every peripheral, reserved bit must stay clear
    reg_write(SMCG_ADDR_PERIPH_GATE, 8'hFF);
    reg_write(4'hF, 8'hFF);
    chk_read(SMCG_ADDR_PERIPH_GATE, 8'hEF);
    chk_read(4'hF, 8'h00);
    `SMCG_CHK(periph_clk_en & 8'hEF, 8'h00);
    `SMCG_CHK(periph_access_en & 8'hEF, 8'h00);
    `SMCG_CHK(comparator_mux_ok, 1'b0);
    @(posedge clk_sys);
    timer_two_async_select <= 1'b1;
    @(posedge clk_sys);
    #1;
    `SMCG_CHK(periph_clk_en[SMCG_PG_TIMER_TWO], 1'b1);
    reg_write(SMCG_ADDR_PERIPH_GATE, 8'h00);
    @(posedge clk_sys);
    #1;
    `SMCG_CHK(periph_clk_en & 8'hEF, 8'hEF);
    `SMCG_CHK(comparator_mux_ok, 1'b1);
    // standby needs a crystal: without it code 110 must not sleep
    for (int i = 0; i < 3; i++) begin
      go_sleep(rsv[i]);
      `SMCG_CHK(core_halted, 1'b0);
    end
    go_sleep(SMCG_MODE_STANDBY);
    `SMCG_CHK(core_halted, 1'b0);
    @(posedge clk_sys);
    converter_enabled <= 1'b1;
    comparator_enabled <= 1'b1;
    chk_read(SMCG_ADDR_STATUS, 8'h10);
    `SMCG_CHK(converter_extended, 1'b1);
    reg_write(SMCG_ADDR_WAKE_CFG, 8'h01);
    chk_read(SMCG_ADDR_WAKE_CFG, 8'h01);
    for (int i = 0; i < 5; i++) begin
      s0 = starts;
      go_sleep(modes[i]);
      `SMCG_CHK({clk_en_cpu, clk_en_flash, clk_en_io, clk_en_adc, osc_main_en, input_buf_en,
                 comparator_active, clk_en_async, osc_timer_en},
                exp_dom[i]);
      `SMCG_CHK(periph_clk_en, (i == 0) ? 8'hEF : 8'h00);
      `SMCG_CHK(watchdog_run, 1'b1);
      `SMCG_CHK(core_halted, 1'b1);
      if (i == 1) begin
        `SMCG_CHK(starts - s0, 1);
      end
      if (i >= 2) begin
        @(posedge clk_sys);
        wk[6] <= 1'b1;
        wk[7] <= 1'b1;
        wk[8] <= 1'b1;
        repeat (20) @(posedge clk_sys);
        wk <= '0;
        timer_two_irq_mask <= 1'b1;
        #1;
        `SMCG_CHK(core_halted, 1'b1);
      end
      wake_by(wsrc[i], n);
      timer_two_irq_mask <= 1'b0;
      if (i == 0) begin
        n_idle = n;
      end
      `SMCG_CHK(n - n_idle, extra[i]);
    end
    chk_read(SMCG_ADDR_STATUS, {4'h0, SMCG_MODE_STANDBY, 1'b0});
    go_sleep(SMCG_MODE_IDLE);
    wake_by(1, n);
    `SMCG_CHK(n_idle - n, SMCG_HALT_EXTRA_CYC);
    `SMCG_CHK(takes, 5);
    stop_test();
  end

  initial begin
    #(100 * 20000);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
